// File: bench/ars_seq_asserts.sv
/* Port checker of the round-robin sequencer.
   Assumes it is bound into ars_sequencer. */
`timescale 1ns/1ps
`default_nettype none
module ars_seq_asserts (
  input wire        clk,
  input wire        srst,
  input wire [7:0]  regAddr,
  input wire [15:0] regWdata,
  input wire        regWr,
  input wire        regRd,
  input wire [15:0] regRdata,
  input wire        convStart,
  input wire [4:0]  convChannel,
  input wire [2:0]  tsBias,
  input wire        unitScaleSel,
  input wire        convDone,
  input wire        irqOutPin
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  rd_idle_a: assert property (!$past(regRd) |-> regRdata == 16'h0000)
    else $error("read data not idle");
  start_pulse_a: assert property (convStart |=> !convStart)
    else $error("start pulse too long");
  stop_skip_a: assert property (convStart |-> convChannel != 5'h1F)
    else $error("stop code converted");
  reserved_skip_a: assert property (convStart |-> !(convChannel inside
    {5'h04, 5'h05, 5'h07, 5'h08, 5'h17, 5'h18, [5'h1A:5'h1E]})) else $error("reserved used");
  bias_clear_a: assert property (convDone |=> tsBias == 3'h0)
    else $error("bias not cleared");
  bias_hold_a: assert property (tsBias != 3'h0 && !convDone
    |=> $stable({tsBias, convChannel})) else $error("selection moved");
  mask_quiet_a: assert property (regWr && regAddr == 8'h05 && regWdata[1] |=> !irqOutPin)
    else $error("masked interrupt");
  scale_follow_a: assert property (regWr && regAddr == 8'h01
    |=> unitScaleSel == $past(regWdata[2])) else $error("scale select");
  cover property (convStart);
  cover property ($rose(irqOutPin));
  cover property (convDone && tsBias != 3'h0);
endmodule
bind ars_sequencer ars_seq_asserts u_chk (.clk, .srst, .regAddr, .regWdata, .regWr, .regRd,
  .regRdata, .convStart, .convChannel, .tsBias, .unitScaleSel, .convDone, .irqOutPin);
`default_nettype wire

// File: bench/ars_sequencer_test.sv
/* Self-checking bench of the sequencer with a converter responder.
   Assumes the sequencer and its checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module ars_sequencer_test;
  logic        clk;
  logic        srst = 1'b1;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic        convDone = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [15:0] regWdata = 16'h0000;
  logic [9:0]  convData = 10'h000;
  wire  [15:0] regRdata;
  wire         convStart;
  wire         unitScaleSel;
  wire         irqOutPin;
  wire  [4:0]  convChannel;
  wire  [2:0]  tsBias;
  integer      error_cnt = 0;
  integer      total_checks = 0;
  integer      i;
  integer      waitCnt;
  logic [7:0]  tbl [0:31];
  logic [10:0] res [0:31];
  integer      pend [$];
  logic        gain = 1'b1;
  logic        sup = 1'b0;
  logic [15:0] v;

  ars_sequencer #(.MS_CYCLES(10), .TICK_CYCLES(2)) u_dut (.clk, .srst, .regAddr, .regWdata,
    .regWr, .regRd, .regRdata, .convStart, .convChannel, .tsBias, .unitScaleSel, .convDone,
    .convData, .irqOutPin);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic complete_run;
    $display("Checks %0d, errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    d = regRdata;
    @(posedge clk);
  endtask

  function automatic bit skip(input logic [4:0] c);
    return (c inside {5'h04, 5'h05, 5'h07, 5'h08, 5'h16, 5'h17, 5'h18, 5'h19, [5'h1A:5'h1E]}) &&
      !(c == 5'h16 && sup);
  endfunction

  // Converter core: answers each start after a random delay
  initial begin : core
    integer s;
    logic [9:0] d;
    forever begin
      @(posedge clk);
      if (convStart === 1'b1) begin
        s = (pend.size() != 0) ? pend.pop_front() : 31;
        check({8'h00, tsBias, convChannel}, {8'h00, tbl[s]});
        d = 10'($urandom);
        repeat ($urandom_range(0, 4)) @(posedge clk);
        convData <= d;
        convDone <= 1'b1;
        res[s] = {gain, d};
        @(posedge clk);
        convDone <= 1'b0;
      end
    end
  end

  task automatic run_round(input logic irqExp, input logic topExp);
    for (i = 0; tbl[i][4:0] != 5'h1F; i++)
      if (!skip(tbl[i][4:0])) pend.push_back(i);
    wr(8'h00, 16'h001F);
    waitCnt = 0;
    do begin
      rd(8'h02, v);
      waitCnt++;
    end while (v[0] !== 1'b1 && waitCnt < 3000);
    if (waitCnt >= 3000) begin
      error_cnt++;
      complete_run();
    end
    wr(8'h00, 16'h001D);
    check({15'h0000, irqOutPin}, {15'h0000, irqExp});
    rd(8'h04, v);
    check(v & 16'h0002, {14'h0000, topExp, 1'b0});
    check(pend.size(), 16'h0000);
    wr(8'h45, 16'h07FF);
    for (i = 0; i < 32; i++) begin
      rd(8'h40 + 8'(i), v);
      check(v, {5'h00, res[i]});
    end
  endtask

  initial begin
    void'($urandom(32'h4BEC));
    for (i = 0; i < 32; i++) begin
      tbl[i] = (i < 7) ? {3'($urandom), 5'($urandom_range(9, 21))} : 8'hFF;
      res[i] = 11'h000;
    end
    tbl[2][4:0] = 5'h04;
    tbl[4][4:0] = 5'h16;
    tbl[5][4:0] = 5'h19;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(8'h00, v);
    check(v, 16'h0000);
    rd(8'h20, v);
    check(v, 16'h001F);
    rd(8'h10, v);
    check(v, 16'h0000);
    check({15'h0000, unitScaleSel}, 16'h0000);
    wr(8'h00, 16'h0002);
    repeat (40) @(posedge clk);
    for (i = 0; i < 7; i++) wr(8'h20 + 8'(i), {8'h00, tbl[i]});
    wr(8'h06, 16'h0001);
    run_round(1'b1, 1'b1);
    wr(8'h02, 16'h0001);
    wr(8'h04, 16'h0002);
    rd(8'h02, v);
    check(v & 16'h0001, 16'h0000);
    check({15'h0000, irqOutPin}, 16'h0000);
    gain = 1'b0;
    sup = 1'b1;
    wr(8'h06, 16'h0000);
    wr(8'h01, 16'h0005);
    check({15'h0000, unitScaleSel}, 16'h0001);
    wr(8'h03, 16'h0001);
    wr(8'h05, 16'h0002);
    run_round(1'b0, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire

// File: rtl/ars_map.vh
/*
  Register offsets, field positions, reset values and timing figures of the
  round-robin ADC sequencer. Assumes a 125 MHz system clock.
*/
`ifndef ARS_MAP_VH
`define ARS_MAP_VH

// Register offsets (8-bit word address)
`define ARS_OFF_CTRL1        8'h00
`define ARS_OFF_EXTRA        8'h01
`define ARS_OFF_IRQ_STAT     8'h02
`define ARS_OFF_IRQ_MASK     8'h03
`define ARS_OFF_TOP_STAT     8'h04
`define ARS_OFF_TOP_MASK     8'h05
`define ARS_OFF_GAIN         8'h06
`define ARS_OFF_STATE        8'h07
`define ARS_OFF_SEL_BASE     8'h20
`define ARS_OFF_RES_BASE     8'h40

// Field positions
`define ARS_BIT_ENABLE       0
`define ARS_BIT_START        1
`define ARS_SLEEP_LO         2
`define ARS_SLEEP_HI         4
`define ARS_BIT_SUPPLY       0
`define ARS_BIT_BACKUP       1
`define ARS_BIT_SCALE        2
`define ARS_BIT_ROUND_DONE   0
`define ARS_BIT_TOP_ADC      1

// Reset values
`define ARS_RST_CTRL1        8'h00
`define ARS_RST_EXTRA        8'h00
`define ARS_RST_MASK         8'h00
`define ARS_RST_SEL          8'h1F

// Channel codes
`define ARS_CH_STOP          5'h1F
`define ARS_CH_SUPPLY        5'h16
`define ARS_CH_BACKUP        5'h19
`define ARS_CH_LAST_FIXED    5'h15

// Timing
`define ARS_CLK_PS           8000
`define ARS_CONV_CLK_KHZ     1330
`define ARS_MS_PS            1000000000
`define ARS_ROUND_MAX_US     15625

// Sleep times in ms per sleep code
`define ARS_SLEEP0_MS        5'd0
`define ARS_SLEEP1_MS        5'd1
`define ARS_SLEEP2_MS        5'd2
`define ARS_SLEEP3_MS        5'd4
`define ARS_SLEEP4_MS        5'd8
`define ARS_SLEEP5_MS        5'd16
`define ARS_SLEEP6_MS        5'd24
`define ARS_SLEEP7_MS        5'd27

`endif

// File: rtl/ars_sequencer.v
/*
  Round-robin sequencer of a 10-bit ADC: selector table, result file, round
  control, sleep timer and round-complete interrupt.
  Assumes an external converter core that answers convStart with convDone
  and convData, a synchronous register port and a 125 MHz clock.
*/
// The placing of the registers and the plain strobed port are this design's own decisions.
// What this block does
// - Holds a 32-entry selector table naming the input for each step.
// - Holds a 32-entry result file of 11-bit entries.
// - Enable bit must be set first; no sequencing while it is low.
// - Start bit makes the block walk the table entries in order.
// - Upper three entry bits drive the touch bias controls during conversion.
// - Lower five entry bits select one of 32 input channels.
// - Each result is stored with the gain setting in its top bit.
// - Channel code 0x1F ends the round without a conversion.
// - Stop entry sets the round-complete flag, bit 0, maskable.
// - Stop entry also sets the summary bit 1 of top status, but only while round-complete mask bit 0 is clear.
// - Interrupt output asserts only while top mask bit 1 is clear.
// - After a round the block sleeps 0 to 27 ms, then repeats.
// - New results overwrite old result entries.
// - A full 32-entry round completes within 15.625 ms.
// - Only 18 channel codes are always defined; the rest are reserved.
// - Channels 22 and 25 work only while their activation bits are 1.
// - Scale select bit, default 0, picks raw or unit scaling.
// - Sequencing runs from an internal tick of about 1.33 MHz.
`timescale 1ns/1ps
`default_nettype none
`include "ars_map.vh"

module ars_sequencer #(
  parameter integer MS_CYCLES   = `ARS_MS_PS / `ARS_CLK_PS,
  parameter integer TICK_CYCLES = (`ARS_MS_PS / `ARS_CLK_PS) / `ARS_CONV_CLK_KHZ
) (
  input  wire        clk,
  input  wire        srst,
  input  wire [7:0]  regAddr,
  input  wire [15:0] regWdata,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [15:0] regRdata,
  output reg         convStart,
  output reg  [4:0]  convChannel,
  output reg  [2:0]  tsBias,
  output reg         unitScaleSel,
  input  wire        convDone,
  input  wire [9:0]  convData,
  output wire        irqOutPin
);

  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_FETCH = 3'd1;
  localparam [2:0] ST_CONV  = 3'd2;
  localparam [2:0] ST_STOP  = 3'd3;
  localparam [2:0] ST_SLEEP = 3'd4;

  reg [7:0]  selTable [0:31];
  reg [10:0] resFile  [0:31];

  reg [7:0]  convControlOne_reg;
  reg [7:0]  convExtraControl_reg;
  reg        roundDoneFlag_reg;
  reg        roundDoneMask_reg;
  reg        topAdcStatus_reg;
  reg        topIrqMask_reg;
  reg        gainSel_reg;
  reg [2:0]  state_reg;
  reg [2:0]  state_next;
  reg [4:0]  step_reg;
  reg [16:0] tickCnt_reg;
  reg [16:0] msPre_reg;
  reg [4:0]  msCnt_reg;
  reg [4:0]  sleepMs;
  reg        chanReserved;

  wire       convEnable  = convControlOne_reg[`ARS_BIT_ENABLE];
  wire       roundStart  = convControlOne_reg[`ARS_BIT_START];
  wire [2:0] roundSleepSel = convControlOne_reg[`ARS_SLEEP_HI:`ARS_SLEEP_LO];
  wire       supplyChanActivate = convExtraControl_reg[`ARS_BIT_SUPPLY];
  wire       backupChanActivate = convExtraControl_reg[`ARS_BIT_BACKUP];
  wire [7:0] curEntry    = selTable[step_reg];
  wire [4:0] curChan     = curEntry[4:0];
  wire       tick        = (tickCnt_reg == 17'h00000);
  wire       runOk       = convEnable && roundStart;
  wire       roundEvent  = (state_reg == ST_STOP);
  wire       selWr       = regWr && (regAddr[7:5] == 3'h1);
  wire       resWr       = (state_reg == ST_CONV) && convDone;
  wire       wrStat      = regWr && (regAddr == `ARS_OFF_IRQ_STAT);
  wire       wrTop       = regWr && (regAddr == `ARS_OFF_TOP_STAT);

  // Reserved channel decode
  always @* begin
    chanReserved = 1'b0;
    if (curChan > `ARS_CH_LAST_FIXED) begin
      chanReserved = 1'b1;
    end
    if (curChan == `ARS_CH_SUPPLY && supplyChanActivate) begin
      chanReserved = 1'b0;
    end
    if (curChan == `ARS_CH_BACKUP && backupChanActivate) begin
      chanReserved = 1'b0;
    end
    case (curChan)
      5'h04, 5'h05, 5'h07, 5'h08: begin
        chanReserved = 1'b1;
      end
      default: ;
    endcase
  end

  // Sleep length per code
  always @* begin
    case (roundSleepSel)
      3'd0: begin
        sleepMs = `ARS_SLEEP0_MS;
      end
      3'd1: begin
        sleepMs = `ARS_SLEEP1_MS;
      end
      3'd2: begin
        sleepMs = `ARS_SLEEP2_MS;
      end
      3'd3: begin
        sleepMs = `ARS_SLEEP3_MS;
      end
      3'd4: begin
        sleepMs = `ARS_SLEEP4_MS;
      end
      3'd5: begin
        sleepMs = `ARS_SLEEP5_MS;
      end
      3'd6: begin
        sleepMs = `ARS_SLEEP6_MS;
      end
      default: begin
        sleepMs = `ARS_SLEEP7_MS;
      end
    endcase
  end

  // Sequencer state machine
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (runOk && tick) begin
          state_next = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (!runOk) begin
          state_next = ST_IDLE;
        end else if (tick) begin
          if (curChan == `ARS_CH_STOP) begin
            state_next = ST_STOP;
          end else if (!chanReserved) begin
            state_next = ST_CONV;
          end
        end
      end
      ST_CONV: begin
        if (convDone) begin
          state_next = runOk ? ST_FETCH : ST_IDLE;
        end
      end
      ST_STOP: begin
        state_next = ST_SLEEP;
      end
      ST_SLEEP: begin
        if (!runOk) begin
          state_next = ST_IDLE;
        end else if (msCnt_reg >= sleepMs) begin
          state_next = ST_FETCH;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Converter tick, sequencing state and converter drive
  always @(posedge clk) begin
    if (srst) begin
      state_reg    <= ST_IDLE;
      step_reg     <= 5'h00;
      tickCnt_reg  <= 17'h00000;
      msPre_reg    <= 17'h00000;
      msCnt_reg    <= 5'h00;
      convStart    <= 1'b0;
      convChannel  <= 5'h00;
      tsBias       <= 3'h0;
    end else begin
      state_reg <= state_next;
      if (tickCnt_reg == TICK_CYCLES[16:0] - 17'h00001) begin
        tickCnt_reg <= 17'h00000;
      end else begin
        tickCnt_reg <= tickCnt_reg + 17'h00001;
      end
      convStart <= 1'b0;
      if (state_reg == ST_FETCH && state_next == ST_CONV) begin
        convStart   <= 1'b1;
        convChannel <= curChan;
        tsBias      <= curEntry[7:5];
      end
      if (state_reg == ST_FETCH && tick && runOk && curChan != `ARS_CH_STOP
          && chanReserved) begin
        step_reg <= step_reg + 5'h01;
      end
      if (resWr) begin
        step_reg <= step_reg + 5'h01;
        tsBias   <= 3'h0;
      end
      if (state_reg == ST_STOP || state_next == ST_IDLE) begin
        step_reg <= 5'h00;
      end
      if (state_reg == ST_SLEEP) begin
        if (msPre_reg == MS_CYCLES[16:0] - 17'h00001) begin
          msPre_reg <= 17'h00000;
          msCnt_reg <= msCnt_reg + 5'h01;
        end else begin
          msPre_reg <= msPre_reg + 17'h00001;
        end
      end else begin
        msPre_reg <= 17'h00000;
        msCnt_reg <= 5'h00;
      end
    end
  end

  // Selector table and result file
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : gEntry
      always @(posedge clk) begin
        if (srst) begin
          selTable[gi] <= `ARS_RST_SEL;
          resFile[gi]  <= 11'h000;
        end else begin
          if (selWr && regAddr[4:0] == gi) begin
            selTable[gi] <= regWdata[7:0];
          end
          if (resWr && step_reg == gi) begin
            resFile[gi] <= {gainSel_reg, convData};
          end
        end
      end
    end
  endgenerate

  // Control and status registers
  always @(posedge clk) begin
    if (srst) begin
      convControlOne_reg   <= `ARS_RST_CTRL1;
      convExtraControl_reg <= `ARS_RST_EXTRA;
      roundDoneFlag_reg    <= 1'b0;
      roundDoneMask_reg    <= 1'b0;
      topAdcStatus_reg     <= 1'b0;
      topIrqMask_reg       <= 1'b0;
      gainSel_reg          <= 1'b0;
      unitScaleSel         <= 1'b0;
    end else begin
      if (regWr && regAddr == `ARS_OFF_CTRL1) begin
        convControlOne_reg <= {3'h0, regWdata[4:0]};
      end
      if (regWr && regAddr == `ARS_OFF_EXTRA) begin
        convExtraControl_reg <= {5'h00, regWdata[2:0]};
        unitScaleSel         <= regWdata[`ARS_BIT_SCALE];
      end
      if (regWr && regAddr == `ARS_OFF_IRQ_MASK) begin
        roundDoneMask_reg <= regWdata[`ARS_BIT_ROUND_DONE];
      end
      if (regWr && regAddr == `ARS_OFF_TOP_MASK) begin
        topIrqMask_reg <= regWdata[`ARS_BIT_TOP_ADC];
      end
      if (regWr && regAddr == `ARS_OFF_GAIN) begin
        gainSel_reg <= regWdata[0];
      end
      if (roundEvent) begin
        roundDoneFlag_reg <= 1'b1;
      end else if (wrStat && regWdata[`ARS_BIT_ROUND_DONE]) begin
        roundDoneFlag_reg <= 1'b0;
      end
      if (roundEvent && !roundDoneMask_reg) begin
        topAdcStatus_reg <= 1'b1;
      end else if (wrTop && regWdata[`ARS_BIT_TOP_ADC]) begin
        topAdcStatus_reg <= 1'b0;
      end
    end
  end

  assign irqOutPin = topAdcStatus_reg && !topIrqMask_reg;

  // Read port, data valid the cycle after the strobe
  always @(posedge clk) begin
    if (srst) begin
      regRdata <= 16'h0000;
    end else if (regRd) begin
      regRdata <= 16'h0000;
      case (regAddr[7:5])
        3'h1: regRdata <= {8'h00, selTable[regAddr[4:0]]};
        3'h2: regRdata <= {5'h00, resFile[regAddr[4:0]]};
        3'h0: begin
          case (regAddr)
            `ARS_OFF_CTRL1: begin
              regRdata <= {8'h00, convControlOne_reg};
            end
            `ARS_OFF_EXTRA: begin
              regRdata <= {8'h00, convExtraControl_reg};
            end
            `ARS_OFF_IRQ_STAT: begin
              regRdata <= {15'h0000, roundDoneFlag_reg};
            end
            `ARS_OFF_IRQ_MASK: begin
              regRdata <= {15'h0000, roundDoneMask_reg};
            end
            `ARS_OFF_TOP_STAT: begin
              regRdata <= {14'h0000, topAdcStatus_reg, 1'b0};
            end
            `ARS_OFF_TOP_MASK: begin
              regRdata <= {14'h0000, topIrqMask_reg, 1'b0};
            end
            `ARS_OFF_GAIN: begin
              regRdata <= {15'h0000, gainSel_reg};
            end
            `ARS_OFF_STATE: begin
              regRdata <= {5'h00, step_reg, 3'h0, state_reg};
            end
            default: begin
              regRdata <= 16'h0000;
            end
          endcase
        end
        default: regRdata <= 16'h0000;
      endcase
    end else begin
      regRdata <= 16'h0000;
    end
  end

endmodule
`default_nettype wire
